// [pkg/svi_cfg.svh]
// Register offsets, field positions and vectors of the interrupt unit
`ifndef SVI_CFG_SVH
`define SVI_CFG_SVH

`define SVI_ADDR_CTRL_PRI   8'h0b
`define SVI_ADDR_CTRL_SEC   8'h1e

`define SVI_BIT_GLOBAL_EN   0
`define SVI_BIT_EXT0_EN     1
`define SVI_BIT_EXT1_EN     2
`define SVI_BIT_CNT0_EN     3
`define SVI_BIT_EXT0_FLAG   4
`define SVI_BIT_EXT1_FLAG   5
`define SVI_BIT_CNT0_FLAG   6
`define SVI_BIT_CNT1_EN     0
`define SVI_BIT_TICK_EN     1
`define SVI_BIT_RTC_EN      2
`define SVI_BIT_CNT1_FLAG   4
`define SVI_BIT_TICK_FLAG   5
`define SVI_BIT_RTC_FLAG    6

`define SVI_VEC_EXT0        8'h04
`define SVI_VEC_EXT1        8'h08
`define SVI_VEC_CNT0        8'h0c
`define SVI_VEC_CNT1        8'h10
`define SVI_VEC_TICK        8'h14
`define SVI_VEC_RTC         8'h18

`define SVI_STACK_DEPTH     5'h10
`define SVI_NUM_SRC         6
`define SVI_CTRL_RESET      8'h00

`endif

// [pkg/svi_pkg.sv]
// Types shared by the interrupt unit and its users
`default_nettype none
package svi_pkg;

    typedef logic [7:0] svi_byte_t;

    // Register port request from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } svi_reg_req_s;

    // Call request to the sequencer: push PC, branch to vector
    typedef struct packed {
        logic       call;
        logic [7:0] vector;
    } svi_call_s;

    typedef enum logic [1:0] {
        SVI_RUN  = 2'b00,
        SVI_HALT = 2'b01
    } svi_power_e;

endpackage : svi_pkg
`default_nettype wire

// [core/svi_irq_unit.sv]
// Six-source vectored interrupt unit with its two control registers
//
// Chosen here: the address-and-strobe port.
`include "svi_cfg.svh"
`default_nettype none

module svi_irq_unit (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire svi_pkg::svi_reg_req_s reg_req,
    output logic [7:0]                reg_rdata,
    input  wire logic                 ext_irq_pin_a_n,
    input  wire logic                 ext_irq_pin_b_n,
    input  wire logic                 counter0_overflow,
    input  wire logic                 counter1_overflow,
    input  wire logic                 tick_pulse,
    input  wire logic                 rtclock_pulse,
    input  wire logic                 clock_phase_two,
    input  wire logic [4:0]           stack_level_pointer,
    input  wire logic                 return_instr,
    input  wire logic                 return_from_irq_instr,
    input  wire logic                 halted,
    output svi_pkg::svi_call_s        call_out,
    output logic                      wake_req
);

    localparam int N = `SVI_NUM_SRC;

    // Source index doubles as priority rank; index 0 wins
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_CNT0 = 2;
    localparam int SRC_CNT1 = 3;
    localparam int SRC_TICK = 4;
    localparam int SRC_RTC  = 5;

    // Pin synchronisers: first stage feeds only the second
    logic [1:0]         pin_raw;
    logic [1:0]         pin_s1_q;
    logic [1:0]         pin_s1_d;
    logic [1:0]         pin_s2_q;
    logic [1:0]         pin_s2_d;
    logic [1:0]         pin_last_q;
    logic [1:0]         pin_last_d;

    // Enables and flags indexed by priority order
    logic               global_en_q;
    logic               global_en_d;
    logic [N-1:0]       enable_q;
    logic [N-1:0]       enable_d;
    logic [N-1:0]       flag_q;
    logic [N-1:0]       flag_d;
    logic [N-1:0]       event_in;
    logic [N-1:0]       wr_en_pri;
    logic [N-1:0]       wr_en_sec;
    logic [N-1:0]       eligible;
    logic [N-1:0]       grant;

    // Arbitration and answers
    logic               stack_full;
    logic               take;
    logic [7:0]         vector_sel;
    logic [7:0]         pri_image;
    logic [7:0]         sec_image;
    logic [7:0]         rdata_d;
    logic [7:0]         rdata_q;
    svi_pkg::svi_call_s call_d;
    svi_pkg::svi_call_s call_q;

    assign pin_raw = {ext_irq_pin_b_n, ext_irq_pin_a_n};

    // One synchroniser and edge history per external pin
    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            always_comb begin
                pin_s1_d[p]   = pin_raw[p];
                pin_s2_d[p]   = pin_s1_q[p];
                pin_last_d[p] = pin_s2_q[p];
            end

            // Reset to the idle high level so release fakes no edge
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_s1_q[p]   <= 1'b1;
                    pin_s2_q[p]   <= 1'b1;
                    pin_last_q[p] <= 1'b1;
                end else begin
                    pin_s1_q[p]   <= pin_s1_d[p];
                    pin_s2_q[p]   <= pin_s2_d[p];
                    pin_last_q[p] <= pin_last_d[p];
                end
            end
        end
    endgenerate

    // Source events in priority order
    always_comb begin
        // Falling edge: high in the history stage, low now
        event_in[SRC_EXT0] = pin_last_q[0] & ~pin_s2_q[0];
        event_in[SRC_EXT1] = pin_last_q[1] & ~pin_s2_q[1];
        event_in[SRC_CNT0] = counter0_overflow;
        event_in[SRC_CNT1] = counter1_overflow;
        event_in[SRC_TICK] = tick_pulse;
        event_in[SRC_RTC]  = rtclock_pulse;
    end

    // Anything at or above sixteen counts as full, so a stray pointer
    // value can never let a push overrun the stack
    assign stack_full = (stack_level_pointer >= `SVI_STACK_DEPTH);

    // Eligible sources; only look when a phase-two pulse arrives
    assign eligible = flag_q & enable_q & {N{global_en_q}};
    assign take     = clock_phase_two & ~stack_full
                      & (|eligible);

    // Lowest index wins
    generate
        for (genvar i = 0; i < N; i++) begin : g_prio
            if (i == 0) begin : g_first
                assign grant[i] = eligible[i];
            end else begin : g_rest
                assign grant[i] = eligible[i] & ~(|eligible[i-1:0]);
            end
        end
    endgenerate

    always_comb begin
        unique case (1'b1)
            grant[0]: vector_sel = `SVI_VEC_EXT0;
            grant[1]: vector_sel = `SVI_VEC_EXT1;
            grant[2]: vector_sel = `SVI_VEC_CNT0;
            grant[3]: vector_sel = `SVI_VEC_CNT1;
            grant[4]: vector_sel = `SVI_VEC_TICK;
            grant[5]: vector_sel = `SVI_VEC_RTC;
            default:  vector_sel = 8'h00;
        endcase
    end

    // Software write strobes for each flag/enable
    logic wr_pri, wr_sec;
    assign wr_pri = reg_req.wr && (reg_req.addr == `SVI_ADDR_CTRL_PRI);
    assign wr_sec = reg_req.wr && (reg_req.addr == `SVI_ADDR_CTRL_SEC);
    assign wr_en_pri = {N{wr_pri}};
    assign wr_en_sec = {N{wr_sec}};

    // Software-visible byte of each flag and enable
    logic [N-1:0] sw_flag, sw_en, sw_wr;
    always_comb begin
        sw_flag = {reg_req.wdata[`SVI_BIT_RTC_FLAG],
                   reg_req.wdata[`SVI_BIT_TICK_FLAG],
                   reg_req.wdata[`SVI_BIT_CNT1_FLAG],
                   reg_req.wdata[`SVI_BIT_CNT0_FLAG],
                   reg_req.wdata[`SVI_BIT_EXT1_FLAG],
                   reg_req.wdata[`SVI_BIT_EXT0_FLAG]};
        sw_en   = {reg_req.wdata[`SVI_BIT_RTC_EN],
                   reg_req.wdata[`SVI_BIT_TICK_EN],
                   reg_req.wdata[`SVI_BIT_CNT1_EN],
                   reg_req.wdata[`SVI_BIT_CNT0_EN],
                   reg_req.wdata[`SVI_BIT_EXT1_EN],
                   reg_req.wdata[`SVI_BIT_EXT0_EN]};
        sw_wr   = {wr_en_sec[5:3], wr_en_pri[2:0]};
    end

    // Flags: hardware set beats any clear in the same cycle
    generate
        for (genvar i = 0; i < N; i++) begin : g_flag
            always_comb begin
                flag_d[i] = flag_q[i];
                if (sw_wr[i]) begin
                    flag_d[i] = sw_flag[i];
                end
                if (take && grant[i]) begin
                    flag_d[i] = 1'b0;
                end
                if (event_in[i]) begin
                    flag_d[i] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Enables change only by software writes
    generate
        for (genvar i = 0; i < N; i++) begin : g_enable
            always_comb begin
                enable_d[i] = sw_wr[i] ? sw_en[i] : enable_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_q <= '0;
        end else begin
            enable_q <= enable_d;
        end
    end

    // Global enable: vectoring clears it, interrupt return sets it
    always_comb begin
        global_en_d = global_en_q;
        if (wr_pri) begin
            global_en_d = reg_req.wdata[`SVI_BIT_GLOBAL_EN];
        end
        if (return_from_irq_instr) begin
            global_en_d = 1'b1;
        end
        if (take) begin
            global_en_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            global_en_q <= 1'b0;
        end else begin
            global_en_q <= global_en_d;
        end
    end

    // Byte images of both registers; spare bits stay 0
    always_comb begin
        pri_image                     = 8'h00;
        pri_image[`SVI_BIT_GLOBAL_EN] = global_en_q;
        pri_image[`SVI_BIT_EXT0_EN]   = enable_q[SRC_EXT0];
        pri_image[`SVI_BIT_EXT1_EN]   = enable_q[SRC_EXT1];
        pri_image[`SVI_BIT_CNT0_EN]   = enable_q[SRC_CNT0];
        pri_image[`SVI_BIT_EXT0_FLAG] = flag_q[SRC_EXT0];
        pri_image[`SVI_BIT_EXT1_FLAG] = flag_q[SRC_EXT1];
        pri_image[`SVI_BIT_CNT0_FLAG] = flag_q[SRC_CNT0];
    end

    always_comb begin
        sec_image                     = 8'h00;
        sec_image[`SVI_BIT_CNT1_EN]   = enable_q[SRC_CNT1];
        sec_image[`SVI_BIT_TICK_EN]   = enable_q[SRC_TICK];
        sec_image[`SVI_BIT_RTC_EN]    = enable_q[SRC_RTC];
        sec_image[`SVI_BIT_CNT1_FLAG] = flag_q[SRC_CNT1];
        sec_image[`SVI_BIT_TICK_FLAG] = flag_q[SRC_TICK];
        sec_image[`SVI_BIT_RTC_FLAG]  = flag_q[SRC_RTC];
    end

    // Read data, one cycle after the read strobe; unmapped reads give 0
    always_comb begin
        rdata_d = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `SVI_ADDR_CTRL_PRI: rdata_d = pri_image;
                `SVI_ADDR_CTRL_SEC: rdata_d = sec_image;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `SVI_CTRL_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Call request: only the PC is pushed by the sequencer
    always_comb begin
        call_d.call   = take;
        call_d.vector = take ? vector_sel : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            call_q <= '0;
        end else begin
            call_q <= call_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign call_out  = call_q;

    // Wake ignores the global enable: a halted core must resume even
    // with interrupts masked, and then carries on where it stopped
    logic [N-1:0] wake_src;
    always_comb begin
        wake_src = flag_q & enable_q;
    end
    assign wake_req  = halted & (|wake_src);

    // Plain return needs no action; listed for completeness of intent
    logic unused_ret;
    assign unused_ret = return_instr;

endmodule // svi_irq_unit
`default_nettype wire

// [sim/svi_irq_chk.sv]
// Port-level assertions for the interrupt unit
`default_nettype none
module svi_irq_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire svi_pkg::svi_reg_req_s reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  clock_phase_two,
    input wire logic [4:0]            stack_level_pointer,
    input wire logic                  halted,
    input wire svi_pkg::svi_call_s    call_out,
    input wire logic                  wake_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_phase;
        call_out.call |-> $past(clock_phase_two);
    endproperty
    a_phase: assert property (p_phase) else $error("call off phase");
    property p_full;
        clock_phase_two && stack_level_pointer >= 5'h10 |=> !call_out.call;
    endproperty
    a_full: assert property (p_full) else $error("call on full");
    property p_vec;
        call_out.call |->
            call_out.vector inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_vec_idle;
        !call_out.call |-> call_out.vector == 8'h00;
    endproperty
    a_vec_idle: assert property (p_vec_idle) else $error("stray vector");
    property p_rd_idle;
        !$past(reg_req.rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    property p_bit7;
        $past(reg_req.rd) |-> !reg_rdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 set");
    property p_bit3;
        $past(reg_req.rd) && $past(reg_req.addr) == 8'h1e |-> !reg_rdata[3];
    endproperty
    a_bit3: assert property (p_bit3) else $error("bit 3 set");
    property p_wake;
        !halted |-> !wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("wake while run");
    c_call: cover property (call_out.call && call_out.vector == 8'h04);
    c_full: cover property (clock_phase_two && stack_level_pointer == 5'h10);
    c_wake: cover property (wake_req);
endmodule // svi_irq_chk
bind svi_irq_unit svi_irq_chk i_svi_irq_chk (.clk, .rst, .reg_req,
    .reg_rdata, .clock_phase_two, .stack_level_pointer, .halted, .call_out,
    .wake_req);
`default_nettype wire

// [sim/svi_core_model.sv]
// Sequencer and return stack model facing the interrupt unit
`default_nettype none
module svi_core_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire svi_pkg::svi_call_s call_out,
    input  wire logic [1:0]         ret_req,
    input  wire logic               fill,
    output logic [4:0]              stack_level_pointer,
    output logic                    clock_phase_two,
    output logic                    return_instr,
    output logic                    return_from_irq_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q;
    // Phase two once per four-clock instruction cycle
    assign clock_phase_two = (cnt_q == 2'h3);
    // Service routines issue no calls of their own
    always_ff @(posedge clk) begin
        cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
        return_instr <= ret_req[0];
        return_from_irq_instr <= ret_req[1];
        if (rst)
            stack_level_pointer <= 5'h00;
        else if (fill)
            stack_level_pointer <= 5'h10;
        else if (call_out.call)
            stack_level_pointer <= stack_level_pointer + 5'h01;
        else if (|ret_req)
            stack_level_pointer <= stack_level_pointer - 5'h01;
    end
endmodule // svi_core_model
`default_nettype wire

// [sim/tb_six_source_vectored_interrupt_unit.sv]
// Self-checking bench for the six-source interrupt unit
`default_nettype none
module tb_six_source_vectored_interrupt_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  halted = 1'b0;
    logic                  fl = 1'b0;
    logic [1:0]            rq = 2'h0;
    logic [5:0]            src = 6'h00;
    logic [7:0]            reg_rdata;
    logic [4:0]            stack_level_pointer;
    logic                  clock_phase_two;
    logic                  return_instr;
    logic                  return_from_irq_instr;
    logic                  wake_req;
    svi_pkg::svi_reg_req_s reg_req = '0;
    svi_pkg::svi_call_s    call_out;
    int                    failures, n_compared, cyc;
    // Pins are active low, so a set bit of src pulls them down
    svi_irq_unit i_svi_irq_unit (.clk, .rst, .reg_req, .reg_rdata,
        .ext_irq_pin_a_n(~src[0]), .ext_irq_pin_b_n(~src[1]),
        .counter0_overflow(src[2]), .counter1_overflow(src[3]),
        .tick_pulse(src[4]), .rtclock_pulse(src[5]), .clock_phase_two,
        .stack_level_pointer, .return_instr, .return_from_irq_instr,
        .halted, .call_out, .wake_req);
    svi_core_model i_svi_core_model (.clk, .rst, .call_out, .ret_req(rq),
        .fill(fl), .stack_level_pointer, .clock_phase_two, .return_instr,
        .return_from_irq_instr);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_req <= {a, d, 2'b10};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        reg_req <= {a, 8'h00, 2'b01};
        @(posedge clk);
        reg_req <= '0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    // Drop events before enabling, else a held event re-sets its flag
    task automatic fire(input logic [5:0] m);
        @(posedge clk);
        src <= m;
        repeat (4) @(posedge clk);
        src <= 6'h00;
        repeat (4) @(posedge clk);
    endtask
    task automatic ret(input logic [1:0] r);
        @(posedge clk);
        rq <= r;
        @(posedge clk);
        rq <= 2'h0;
    endtask
    task automatic wait_call(input logic [7:0] e);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (call_out.call !== 1'b1 && k < 16);
        chk(call_out.vector, e);
    endtask
    task automatic quiet;
        repeat (12) begin
            @(negedge clk);
            chk({7'h00, call_out.call}, 8'h00);
        end
    endtask
    task automatic t_regs;
        rd(8'h0b, 8'h00);
        rd(8'h1e, 8'h00);
        wr(8'h0b, 8'h8e);
        wr(8'h1e, 8'hff);
        wr(8'h0c, 8'hff);
        rd(8'h0b, 8'h0e);
        rd(8'h1e, 8'h77);
        rd(8'h0c, 8'h00);
        wr(8'h1e, 8'h00);
    endtask
    task automatic t_prio;
        logic [5:0] m;
        wr(8'h1e, 8'h07);
        fire(6'h3f);
        rd(8'h0b, 8'h7e);
        rd(8'h1e, 8'h77);
        wr(8'h0b, 8'h7f);
        for (int i = 0; i < 6; i++) begin
            wait_call(8'(4 * i + 4));
            m = 6'h3e << i;
            rd(8'h0b, {1'b0, m[2:0], 4'he});
            rd(8'h1e, {1'b0, m[5:3], 4'h7});
            ret(2'b10);
        end
        rd(8'h0b, 8'h0f);
        wr(8'h0b, 8'h01);
        wr(8'h1e, 8'h00);
        fire(6'h04);
        quiet();
        rd(8'h0b, 8'h41);
        wr(8'h0b, 8'h00);
        rd(8'h0b, 8'h00);
    endtask
    task automatic t_full;
        @(posedge clk);
        fl <= 1'b1;
        @(posedge clk);
        fl <= 1'b0;
        wr(8'h1e, 8'h02);
        fire(6'h10);
        wr(8'h0b, 8'h01);
        quiet();
        ret(2'b01);
        wait_call(8'h14);
        ret(2'b01);
        rd(8'h0b, 8'h00);
        ret(2'b10);
        rd(8'h0b, 8'h01);
    endtask
    task automatic t_wake;
        wr(8'h0b, 8'h00);
        halted <= 1'b1;
        wr(8'h1e, 8'h01);
        @(negedge clk);
        chk({7'h00, wake_req}, 8'h00);
        fire(6'h08);
        @(negedge clk);
        chk({7'h00, wake_req}, 8'h01);
        wr(8'h1e, 8'h00);
        halted <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_prio();
        t_full();
        t_wake();
        tally_and_finish();
    end
endmodule // tb_six_source_vectored_interrupt_unit
`default_nettype wire
